// [verilog/emp_port.sv]
// external memory port: apb registers, bus arbitration, access sequencer
// Summary of operation
// - reads and writes add 0 to 7 memory clock waitstates per space.
// - wait mode picks ack only, count only, both, or either to end.
// - divider code 0 to 5 sets memory clock 1:1 to 1:32.
// - write hold bit keeps write data one memory clock period after strobe ends.
// - four banks, boot and io space each have their own settings.
// - four 8-bit lower page fields, two per 16-bit register.
// - default boundaries give banks 1 and 2 64 pages each, bank 0 65 and bank 3 63.
// - bus width bit selects 16-bit or 8-bit external bus.
// - strobe sense bits make read or write strobe active low.
// - format bit makes bus data 24 or 16 bit; fetches ignore it.
// - words are split over bus beats and rebuilt on reads.
// - split bit lets other dma use internal memory while waiting.
// - enabled selects are ored into one composite select.
// - bus lock ignores bus requests, device stays master.
// - hold-off delays bus request response by 16 cycles.
// - control lock makes space control registers unwritable.
// - boot instruction enable routes fetches to boot select.
// - boot program bus data enable routes pm data to boot select.
// - boot data bus enable routes dm data to boot select.
// - three internal buses share the port; packing a fetch read adds one cycle.
// - idle port answers bus request by tri-stating, then granting.
// - ack only mode lasts at least two waitstates.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module emp_port
  import emp_pkg::*;
#(
  parameter int NREQ = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NREQ-1:0] req_valid_i,
  input wire emp_req_t [NREQ-1:0] req_i,
  output logic [NREQ-1:0] req_done_o,
  output logic [23:0] req_rdata_o,
  output logic dma_other_wait_o,
  output logic [25:0] ext_addr_o,
  output logic [15:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [15:0] ext_data_i,
  output logic ctrl_oe_o,
  output logic read_strobe_o,
  output logic write_strobe_o,
  output logic [3:0] bank_select_n_o,
  output logic boot_space_select_n_o,
  output logic io_select_n_o,
  output logic composite_select_n_o,
  output logic memory_side_clock_o,
  input wire logic ack_i,
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o
);
  logic [15:0] space_ctl [NSPACE];
  logic [15:0] pg10;
  logic [15:0] pg32;
  logic [15:0] ext_ctl;
  logic [15:0] fmt_boot;
  emp_state_t st;
  emp_req_t cur;
  logic [1:0] sel;
  logic [2:0] space;
  logic [1:0] beat;
  logic [1:0] last_beat;
  logic [2:0] ws_cnt;
  logic [4:0] hold_cnt;
  logic [31:0] rbuf;
  logic tick;
  logic mclk;
  logic restart;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [15:0] rd_val;
  emp_space_ctl_t cfg;
  logic [2:0] ws_target;
  logic cnt_ok;
  logic ack_ok;
  logic end_ok;
  logic step;
  logic any_req;
  logic [1:0] pick;
  logic [2:0] pick_space;
  logic [7:0] page;
  logic [1:0] pick_bank;
  logic bus16;
  logic word24;
  logic [1:0] pick_last;
  logic [4:0] shift;
  logic [31:0] wd_shift;
  logic strobe_on;
  logic cap_q;
  logic [1:0] cap_beat;
  logic pack_q;
  logic hold_pick;
  logic [31:0] rword;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // apb address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_val = 16'h0000;
    case (paddr)
      REG_BANK0_CTL: rd_val = space_ctl[0];
      REG_BANK1_CTL: rd_val = space_ctl[1];
      REG_BANK2_CTL: rd_val = space_ctl[2];
      REG_BANK3_CTL: rd_val = space_ctl[3];
      REG_BOOT_CTL: rd_val = space_ctl[SP_BOOT];
      REG_IO_CTL: rd_val = space_ctl[SP_IO];
      REG_PG10: rd_val = pg10;
      REG_PG32: rd_val = pg32;
      REG_EXT_CTL: rd_val = ext_ctl;
      REG_FMT_BOOT: begin
        rd_val = fmt_boot;
        rd_val[WPF_BIT] = (st != ST_IDLE) && cur.write && (st < ST_HOLDOFF);
      end
      default: mapped = 1'b0;
    endcase
  end

  // apb answer: one access cycle, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= {16'h0000, rd_val};
      end
    end
  end

  // per space control words, frozen by the lock bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSPACE; i++) begin
        space_ctl[i] <= SPACE_CTL_RST;
      end
    end else if (wr_en && !ext_ctl[CRL_BIT] && mapped && paddr <= REG_IO_CTL) begin
      space_ctl[paddr[4:2]] <= pwdata[15:0];
    end
  end

  // page boundaries, interface control, format and boot selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg10 <= PG10_RST;
      pg32 <= PG32_RST;
      ext_ctl <= EXT_CTL_RST;
      fmt_boot <= FMT_BOOT_RST;
    end else if (wr_en) begin
      if (paddr == REG_PG10) pg10 <= pwdata[15:0];
      if (paddr == REG_PG32) pg32 <= pwdata[15:0];
      if (paddr == REG_EXT_CTL) ext_ctl <= pwdata[15:0];
      if (paddr == REG_FMT_BOOT) fmt_boot <= pwdata[15:0] & FMT_WR_MASK;
    end
  end

  // arbitration: dma first, then data bus, then program bus
  // no new pick until the finished request has seen its done pulse
  always_comb begin
    hold_pick = cap_q || pack_q || (|req_done_o);
    any_req = (|req_valid_i) && !hold_pick;
    pick = 2'(RQ_PM);
    if (req_valid_i[RQ_DMA]) begin
      pick = 2'(RQ_DMA);
    end else if (req_valid_i[RQ_DM]) begin
      pick = 2'(RQ_DM);
    end
  end

  // space of the picked request from page boundaries and boot enables
  always_comb begin
    page = req_i[pick].addr[23:16];
    if (page >= pg32[15:8]) begin
      pick_bank = 2'd3;
    end else if (page >= pg32[7:0]) begin
      pick_bank = 2'd2;
    end else if (page >= pg10[15:8]) begin
      pick_bank = 2'd1;
    end else begin
      pick_bank = 2'd0;
    end
    pick_space = {1'b0, pick_bank};
    if (req_i[pick].io) begin
      pick_space = SP_IO;
    end else if (req_i[pick].instr && fmt_boot[PI_BE_BIT]) begin
      pick_space = SP_BOOT;
    end else if (pick == 2'(RQ_PM) && !req_i[pick].instr && fmt_boot[PD_BE_BIT]) begin
      pick_space = SP_BOOT;
    end else if (pick == 2'(RQ_DM) && fmt_boot[DD_BE_BIT]) begin
      pick_space = SP_BOOT;
    end
  end

  // index of the last beat of a word (beats per word minus one)
  always_comb begin
    bus16 = ext_ctl[BWS_BIT];
    word24 = req_i[pick].instr || fmt_boot[DFS_BIT];
    if (bus16) begin
      pick_last = word24 ? 2'd1 : 2'd0;
    end else begin
      pick_last = word24 ? 2'd2 : 2'd1;
    end
  end

  // end of strobe by wait mode
  always_comb begin
    cfg = emp_space_ctl_t'(space_ctl[space]);
    ws_target = cur.write ? cfg.wwc : cfg.rwc;
    cnt_ok = ws_cnt >= ws_target;
    ack_ok = ack_i && ws_cnt >= ACK_MIN_WS;
    case (emp_wait_mode_t'(cfg.wms))
      WM_ACK: end_ok = ack_ok;
      WM_WAIT: end_ok = cnt_ok;
      WM_BOTH: end_ok = cnt_ok && ack_ok;
      WM_EITHER: end_ok = cnt_ok || ack_ok;
      default: end_ok = cnt_ok;
    endcase
    step = (st == ST_STROBE && tick && end_ok && !(cur.write && cfg.whe)) || (st == ST_HOLD && tick);
  end

  assign restart = (st == ST_IDLE);

  emp_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .cds_i(cfg.cds),
    .tick_o(tick),
    .level_o(mclk)
  );

  // sequencer and bus grant state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      cur <= '0;
      sel <= 2'd0;
      space <= 3'd0;
      beat <= 2'd0;
      last_beat <= 2'd0;
      ws_cnt <= 3'd0;
      hold_cnt <= 5'd0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (!bus_request_n_i && !ext_ctl[BL_BIT]) begin
            hold_cnt <= 5'd0;
            st <= ext_ctl[BHE_BIT] ? ST_HOLDOFF : ST_RELEASE;
          end else if (any_req) begin
            cur <= req_i[pick];
            sel <= pick;
            space <= pick_space;
            beat <= 2'd0;
            last_beat <= pick_last;
            ws_cnt <= 3'd0;
            st <= ST_STROBE;
          end
        end
        ST_STROBE, ST_HOLD: begin
          if (st == ST_STROBE && tick && ws_cnt != 3'd7) begin
            ws_cnt <= ws_cnt + 3'd1;
          end
          if (st == ST_STROBE && tick && end_ok && cur.write && cfg.whe) begin
            st <= ST_HOLD;
          end else if (step) begin
            ws_cnt <= 3'd0;
            if (beat != last_beat) begin
              beat <= beat + 2'd1;
              st <= ST_STROBE;
            end else if (cur.instr && !cur.write) begin
              st <= ST_PACK;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
        ST_PACK: st <= ST_IDLE;
        ST_HOLDOFF: begin
          hold_cnt <= hold_cnt + 5'd1;
          if (bus_request_n_i) begin
            st <= ST_IDLE;
          end else if (hold_cnt == HOLDOFF_LAST) begin
            st <= ST_RELEASE;
          end
        end
        ST_RELEASE: st <= ST_GRANT;
        ST_GRANT: begin
          if (bus_request_n_i) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // beat merged into the word; pins lag state, so data is taken one cycle after the step
  always_comb begin
    rword = rbuf;
    if (ext_ctl[BWS_BIT]) begin
      rword[{cap_beat[0], 4'h0} +: 16] = ext_data_i;
    end else begin
      rword[{cap_beat, 3'h0} +: 8] = ext_data_i[7:0];
    end
  end

  // read beats rebuilt into the word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rbuf <= 32'h0000_0000;
      cap_q <= 1'b0;
      cap_beat <= 2'd0;
      pack_q <= 1'b0;
    end else begin
      cap_q <= (st == ST_STROBE) && step && !cur.write;
      cap_beat <= beat;
      pack_q <= (st == ST_PACK);
      if (cap_q) begin
        rbuf <= rword;
      end
    end
  end

  // completion pulse and read data back to the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_done_o <= '0;
      req_rdata_o <= 24'h000000;
    end else begin
      req_done_o <= '0;
      if ((step && beat == last_beat && cur.write) || (cap_q && cap_beat == last_beat && !cur.instr)) begin
        req_done_o[sel] <= 1'b1;
        req_rdata_o <= rword[23:0];
      end else if (pack_q) begin
        req_done_o[sel] <= 1'b1;
        req_rdata_o <= rbuf[23:0];
      end
    end
  end

  always_comb begin
    shift = ext_ctl[BWS_BIT] ? {beat[0], 4'h0} : {beat, 3'h0};
    wd_shift = {8'h00, cur.wdata} >> shift;
    strobe_on = (st == ST_STROBE);
  end

  // pins, each from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_addr_o <= 26'h0000000;
      ext_data_o <= 16'h0000;
      ext_data_oe_o <= 1'b0;
      ctrl_oe_o <= 1'b1;
      read_strobe_o <= 1'b1;
      write_strobe_o <= 1'b1;
      bank_select_n_o <= 4'hf;
      boot_space_select_n_o <= 1'b1;
      io_select_n_o <= 1'b1;
      composite_select_n_o <= 1'b1;
      memory_side_clock_o <= 1'b0;
      bus_grant_n_o <= 1'b1;
      dma_other_wait_o <= 1'b0;
    end else begin
      ext_addr_o <= {cur.addr, beat};
      ext_data_o <= wd_shift[15:0];
      ext_data_oe_o <= cur.write && (st == ST_STROBE || st == ST_HOLD);
      ctrl_oe_o <= !(st == ST_RELEASE || st == ST_GRANT);
      bus_grant_n_o <= !(st == ST_GRANT);
      read_strobe_o <= ext_ctl[RLS_BIT] ^ (strobe_on && !cur.write);
      write_strobe_o <= ext_ctl[WLS_BIT] ^ (strobe_on && cur.write);
      for (int b = 0; b < 4; b++) begin
        bank_select_n_o[b] <= !(strobe_on && space == 3'(b));
      end
      boot_space_select_n_o <= !(strobe_on && space == SP_BOOT);
      io_select_n_o <= !(strobe_on && space == SP_IO);
      composite_select_n_o <= !(strobe_on && cfg.coe);
      memory_side_clock_o <= mclk;
      dma_other_wait_o <= (st != ST_IDLE) && (st < ST_HOLDOFF) && sel == 2'(RQ_DMA)
                          && !ext_ctl[ASE_BIT];
    end
  end
endmodule // emp_port
`default_nettype wire

// [common/emp_pkg.sv]
// constants, layouts and types for the external memory port configuration block
`default_nettype none
package emp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] REG_BANK0_CTL = 8'h00;
  localparam logic [7:0] REG_BANK1_CTL = 8'h04;
  localparam logic [7:0] REG_BANK2_CTL = 8'h08;
  localparam logic [7:0] REG_BANK3_CTL = 8'h0c;
  localparam logic [7:0] REG_BOOT_CTL = 8'h10;
  localparam logic [7:0] REG_IO_CTL = 8'h14;
  localparam logic [7:0] REG_PG10 = 8'h18;
  localparam logic [7:0] REG_PG32 = 8'h1c;
  localparam logic [7:0] REG_EXT_CTL = 8'h20;
  localparam logic [7:0] REG_FMT_BOOT = 8'h24;
  // reset values
  localparam logic [15:0] SPACE_CTL_RST = 16'h007f;
  localparam logic [15:0] PG10_RST = 16'h4101;
  localparam logic [15:0] PG32_RST = 16'hc181;
  localparam logic [15:0] EXT_CTL_RST = 16'h0038;
  localparam logic [15:0] FMT_BOOT_RST = 16'h0000;
  // external interface control bits
  localparam int BL_BIT = 0;
  localparam int BHE_BIT = 1;
  localparam int CRL_BIT = 2;
  localparam int BWS_BIT = 3;
  localparam int WLS_BIT = 4;
  localparam int RLS_BIT = 5;
  localparam int ASE_BIT = 6;
  // format and boot select bits
  localparam int PI_BE_BIT = 0;
  localparam int PD_BE_BIT = 1;
  localparam int DD_BE_BIT = 2;
  localparam int DFS_BIT = 3;
  localparam int WPF_BIT = 8;
  localparam logic [15:0] FMT_WR_MASK = 16'h000f;
  // space indices and requester indices
  localparam logic [2:0] SP_BOOT = 3'd4;
  localparam logic [2:0] SP_IO = 3'd5;
  localparam int NSPACE = 6;
  localparam int RQ_PM = 0;
  localparam int RQ_DM = 1;
  localparam int RQ_DMA = 2;
  // timing figures
  localparam logic [2:0] ACK_MIN_WS = 3'd2;
  localparam logic [4:0] HOLDOFF_LAST = 5'd15;
  localparam logic [2:0] DIV_MAX_CODE = 3'd5;
  // per bank or space control word layout
  typedef struct packed {
    logic coe;
    logic [2:0] rsv;
    logic whe;
    logic [2:0] cds;
    logic [1:0] wms;
    logic [2:0] wwc;
    logic [2:0] rwc;
  } emp_space_ctl_t;
  typedef enum logic [1:0] {
    WM_ACK = 2'b00,
    WM_WAIT = 2'b01,
    WM_BOTH = 2'b10,
    WM_EITHER = 2'b11
  } emp_wait_mode_t;
  // one internal bus request
  typedef struct packed {
    logic write;
    logic instr;
    logic io;
    logic [23:0] addr;
    logic [23:0] wdata;
  } emp_req_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STROBE = 3'b001,
    ST_HOLD = 3'b010,
    ST_PACK = 3'b011,
    ST_HOLDOFF = 3'b100,
    ST_RELEASE = 3'b101,
    ST_GRANT = 3'b110
  } emp_state_t;
endpackage
`default_nettype wire

// [verilog/emp_clk_div.sv]
// memory clock divider giving one tick per memory clock period
`default_nettype none
module emp_clk_div
  import emp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [2:0] cds_i,
  output logic tick_o,
  output logic level_o
);
  logic [4:0] cnt;
  logic [2:0] code;
  logic [4:0] last;

  // codes above the largest ratio clamp to it
  always_comb begin
    code = (cds_i > DIV_MAX_CODE) ? DIV_MAX_CODE : cds_i;
    last = 5'(({1'b0, 5'h1f}) >> (DIV_MAX_CODE - code));
  end

  // free count restarted at each access
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || cnt == last) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

  // tick on the last peripheral cycle of a memory period
  always_comb begin
    tick_o = (cnt == last);
    level_o = (cnt <= (last >> 1));
  end
endmodule // emp_clk_div
`default_nettype wire

// [bench/emp_port_monitor.sv]
// assertion checker bound to the external memory port
`default_nettype none
module emp_port_monitor
  import emp_pkg::*;
#(
  parameter int NREQ = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NREQ-1:0] req_valid_i,
  input wire logic [NREQ-1:0] req_done_o,
  input wire logic dma_other_wait_o,
  input wire logic ext_data_oe_o,
  input wire logic ctrl_oe_o,
  input wire logic bus_request_n_i,
  input wire logic bus_grant_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // register bus answers
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer) else $error("no access cycle after setup");
  property p_err;
    pslverr |-> s_access;
  endproperty
  a_err: assert property (p_err) else $error("error outside access cycle");
  property p_upper;
    pready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data above bit 15");
  // completion pulses
  property p_done_pulse;
    |req_done_o |=> req_done_o == '0;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_one;
    $onehot0(req_done_o);
  endproperty
  a_done_one: assert property (p_done_one) else $error("two buses done at once");
  // bus hand-over
  property p_grant_off;
    !bus_grant_n_o |-> !ctrl_oe_o && !ext_data_oe_o;
  endproperty
  a_grant_off: assert property (p_grant_off) else $error("pins driven while granted");
  property p_grant_path;
    $fell(bus_grant_n_o) |-> $past(!ctrl_oe_o) && !bus_request_n_i;
  endproperty
  a_grant_path: assert property (p_grant_path) else $error("grant without release");
  property p_grant_drop;
    !bus_grant_n_o && bus_request_n_i |-> ##[1:2] bus_grant_n_o;
  endproperty
  a_grant_drop: assert property (p_grant_drop) else $error("grant kept after request");
  property p_data_oe;
    ext_data_oe_o |-> ctrl_oe_o;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data driven while released");
  property p_dma_wait;
    dma_other_wait_o |-> req_valid_i[RQ_DMA] || $past(req_valid_i[RQ_DMA]);
  endproperty
  a_dma_wait: assert property (p_dma_wait) else $error("dma wait without dma access");
endmodule // emp_port_monitor
bind emp_port emp_port_monitor #(.NREQ(NREQ)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid_i(req_valid_i),
  .req_done_o(req_done_o), .dma_other_wait_o(dma_other_wait_o), .ext_data_oe_o(ext_data_oe_o),
  .ctrl_oe_o(ctrl_oe_o), .bus_request_n_i(bus_request_n_i), .bus_grant_n_o(bus_grant_n_o));
`default_nettype wire

// [bench/emp_mem_model.sv]
// external memory model answering the port strobes
`default_nettype none
module emp_mem_model
#(
  parameter int ACK_DLY = 3
) (
  input wire logic clk_i,
  input wire logic [25:0] addr_i,
  input wire logic rd_strobe_i,
  input wire logic wr_strobe_i,
  input wire logic rd_sense_i,
  input wire logic wr_sense_i,
  output logic [15:0] data_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy = 0;
  logic [15:0] last = 16'h0000;
  logic rd_act;
  logic act;
  // a strobe is active when its level differs from its sense bit
  assign rd_act = rd_strobe_i ^ rd_sense_i;
  assign act = rd_act | (wr_strobe_i ^ wr_sense_i);
  // read data only while the read strobe is active, a changing pattern otherwise
  assign data_o = rd_act ? (addr_i[15:0] ^ 16'h5a5a) : ~last;
  // ack stays low until the access has had its time
  always @(posedge clk_i) begin
    last <= data_o;
    busy <= act ? busy + 1 : 0;
    ack_o <= act && busy >= ACK_DLY;
  end
endmodule // emp_mem_model
`default_nettype wire

// [bench/emp_port_tb.sv]
// self-checking bench for the external memory port
`default_nettype none
module emp_port_tb
  import emp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic [2:0] req_valid_i = 0, req_done_o;
  emp_req_t [2:0] req_i = '0;
  logic [23:0] req_rdata_o;
  logic [25:0] ext_addr_o;
  logic [15:0] ext_data_o, ext_data_i;
  logic [3:0] bank_select_n_o;
  logic dma_other_wait_o, ext_data_oe_o, ctrl_oe_o, read_strobe_o, write_strobe_o, boot_space_select_n_o;
  logic io_select_n_o, composite_select_n_o, memory_side_clock_o, ack_i, bus_request_n_i = 1, bus_grant_n_o;
  logic rs = 1, wsn = 1;
  logic [6:0] sel;
  logic [32:0] q[$];
  logic [15:0] cq[$];
  logic [31:0] sv[6];
  int fails = 0, comparisons = 0, lat[4], l0, l7, lc, h0, h1;
  localparam logic [23:0] A = 24'h012344;
  emp_port DUT (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_done_o(req_done_o), .req_rdata_o(req_rdata_o), .dma_other_wait_o(dma_other_wait_o),
    .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o), .ext_data_i(ext_data_i),
    .ctrl_oe_o(ctrl_oe_o), .read_strobe_o(read_strobe_o), .write_strobe_o(write_strobe_o),
    .bank_select_n_o(bank_select_n_o), .boot_space_select_n_o(boot_space_select_n_o),
    .io_select_n_o(io_select_n_o), .composite_select_n_o(composite_select_n_o),
    .memory_side_clock_o(memory_side_clock_o), .ack_i(ack_i), .bus_request_n_i(bus_request_n_i),
    .bus_grant_n_o(bus_grant_n_o));
  emp_mem_model u_mem (.clk_i(clk_i), .addr_i(ext_addr_o), .rd_strobe_i(read_strobe_o),
    .wr_strobe_i(write_strobe_o), .rd_sense_i(rs), .wr_sense_i(wsn), .data_o(ext_data_i), .ack_o(ack_i));
  // clock
  initial forever #50 clk_i = ~clk_i;
  // compare and count
  task chk(input logic [63:0] s, input logic [63:0] e, input string n);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, read expectation queued
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    if (!w) q.push_back(e);
    @(posedge clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    psel <= 0; penable <= 0;
    if (n == 20) begin fails++; end_sim(); end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d, 0); endtask
  task rd(input logic [7:0] a, input logic [31:0] e); apb(0, a, 0, {1'b0, e}); endtask
  task ectl(input logic [31:0] d);
    wr(REG_EXT_CTL, d);
    rs <= d[RLS_BIT];
    wsn <= d[WLS_BIT];
  endtask
  // one core request; returns latency and selects seen
  task core(input int r, input logic [1:0] k, input logic [23:0] a, output int l, output logic [6:0] s);
    s = 0;
    l = -1;
    @(posedge clk_i);
    req_valid_i[r] <= 1;
    req_i[r] <= {k, 1'b0, a, 24'h00a5c3};
    for (int n = 1; n < 2000; n++) begin
      @(posedge clk_i);
      s = s | {dma_other_wait_o, ~composite_select_n_o, ~boot_space_select_n_o, ~bank_select_n_o};
      if (req_done_o[r] === 1'b1) begin l = n; break; end
    end
    req_valid_i[r] <= 0;
    if (l < 0) begin fails++; end_sim(); end
  endtask
  task breq(output int l);
    l = -1;
    @(posedge clk_i);
    bus_request_n_i <= 0;
    for (int n = 1; n < 60; n++) begin
      @(posedge clk_i);
      if (bus_grant_n_o === 1'b0) begin l = n; break; end
    end
    bus_request_n_i <= 1;
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic [15:0] mem(input logic [1:0] b);
    return {A[13:0], b} ^ 16'h5a5a;
  endfunction
  // scoreboard watching results
  always @(posedge clk_i) begin
    if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, q.pop_front(), "apb_read");
    if (req_done_o[RQ_DM] === 1'b1 && req_i[RQ_DM].write === 1'b0)
      chk(req_rdata_o[15:0], cq.pop_front(), "core_read");
  end
  // main sequence
  initial begin
    void'($urandom(32'hb7f340ff));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), {16'h0, SPACE_CTL_RST});
    rd(REG_PG10, {16'h0, PG10_RST});
    rd(REG_PG32, {16'h0, PG32_RST});
    rd(REG_EXT_CTL, {16'h0, EXT_CTL_RST});
    rd(REG_FMT_BOOT, {16'h0, FMT_BOOT_RST});
    apb(0, 8'h28, 0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      sv[i] = $urandom & 32'hffff8fff;
      wr(8'(4 * i), sv[i]);
      rd(8'(4 * i), sv[i] & 32'h8fff);
    end
    v = $urandom;
    wr(REG_PG32, v);
    rd(REG_PG32, v & 32'hffff);
    wr(REG_PG32, PG32_RST);
    wr(REG_FMT_BOOT, 32'hfff0);
    rd(REG_FMT_BOOT, 32'h0);
    ectl(32'h3c);
    wr(REG_BANK0_CTL, 32'h0040);
    rd(REG_BANK0_CTL, sv[0] & 32'h8fff);
    ectl(32'h38);
    // waitstate count and divider
    wr(REG_BANK0_CTL, 32'h0040);
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, l0, sel);
    chk(sel, 7'h01, "select");
    wr(REG_BANK0_CTL, 32'h0047);
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, l7, sel);
    chk(l7 - l0, 7, "wait_count");
    wr(REG_BANK0_CTL, 32'h0240);
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, lc, sel);
    chk(lc > l0, 1, "divider");
    // all four ending modes, composite select on
    for (int m = 0; m < 4; m++) begin
      wr(REG_BANK0_CTL, 32'h8007 | (m << 6));
      cq.push_back(mem(0));
      core(RQ_DM, 0, A, lat[m], sel);
      chk(sel, 7'h21, "composite");
    end
    chk(lat[3] < lat[2], 1, "either_mode");
    chk(lat[0] < lat[1], 1, "ack_mode");
    // strobe sense and narrow bus
    wr(REG_BANK0_CTL, 32'h0040);
    ectl(32'h18);
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, lc, sel);
    ectl(32'h30);
    cq.push_back({mem(1) & 16'hff, 8'h0} | (mem(0) & 16'hff));
    core(RQ_DM, 0, A, lc, sel);
    ectl(32'h38);
    // boot space routing
    wr(REG_FMT_BOOT, 32'h4);
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, lc, sel);
    chk(sel[4:0], 5'h10, "boot_dm");
    wr(REG_FMT_BOOT, 32'h2);
    core(RQ_PM, 0, A, lc, sel);
    chk(sel[4:0], 5'h10, "boot_pm");
    wr(REG_FMT_BOOT, 32'h1);
    core(RQ_PM, 2'b01, A, lc, sel);
    chk(sel[4:0], 5'h10, "boot_fetch");
    cq.push_back(mem(0));
    core(RQ_DM, 0, A, lc, sel);
    chk(sel[4:0], 5'h01, "bank_dm");
    wr(REG_FMT_BOOT, 32'h0);
    // dma split
    core(RQ_DMA, 2'b10, A, lc, sel);
    chk(sel[6], 1, "dma_wait");
    ectl(32'h78);
    core(RQ_DMA, 2'b10, A, lc, sel);
    chk(sel[6], 0, "dma_split");
    // bus requests: plain, held off, locked
    ectl(32'h38);
    breq(h0);
    chk(h0 > 0, 1, "grant");
    ectl(32'h3a);
    breq(h1);
    chk(h1 - h0, 16, "holdoff");
    ectl(32'h39);
    breq(h1);
    chk(h1, -1, "lock");
    end_sim();
  end
endmodule // emp_port_tb
`default_nettype wire
